/* rtl/pua_port.sv */
// Purpose: Eight-pin port carrying upper address or general I/O.
// Assumes: APB slave, 25 MHz pclk, pins synchronised on entry.
// Notes:   Mode and standby inputs come from system logic on pclk.
`timescale 1ns/1ps
module pua_port
    import pua_pkg::*;
#(
    parameter int WIDTH = PUA_WIDTH
)(
    // APB clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave port.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Chip mode and standby state.
    input  wire logic [1:0]        mode,
    input  wire logic              hw_standby,
    input  wire logic              sw_standby,
    // Upper address from the bus controller.
    input  wire logic [WIDTH-1:0]  upper_addr,
    // Pins.
    input  wire logic [WIDTH-1:0]  pin_in,
    output logic      [WIDTH-1:0]  pin_out,
    output logic      [WIDTH-1:0]  pin_oe,
    output logic      [WIDTH-1:0]  pullup_on
);

    ////////////////////////////////////////////////////////////////////
    // Registers and synchronisers.

    logic [WIDTH-1:0] pin_direction;      // Stored direction bits.
    logic [WIDTH-1:0] pin_output_data;    // Output data register.
    logic [WIDTH-1:0] pin_pullup_enable;  // Pull-up enables.
    logic [WIDTH-1:0] next_pin_direction;
    logic [WIDTH-1:0] next_pin_output_data;
    logic [WIDTH-1:0] next_pin_pullup_enable;
    logic [WIDTH-1:0] pin_meta;           // First synchroniser stage.
    logic [WIDTH-1:0] pin_sync;           // Second synchroniser stage.
    logic [WIDTH-1:0] read_bits;          // Per-pin port readback.
    logic [31:0]      next_prdata;        // Read data for this access.
    logic             next_pslverr;       // Error flag for this access.
    logic             in_reset;           // Held high until first edge.
    logic             wr_en;              // Write takes effect this edge.
    logic             rd_en;              // Read data captured this edge.
    logic             addr_hit;           // Address maps to a register.

    ////////////////////////////////////////////////////////////////////
    // APB decode. The slave answers in the access phase with no wait.

    always_comb begin
        pready   = 1'b1;
        wr_en    = psel && penable && pwrite;
        rd_en    = psel && !penable && !pwrite;
        addr_hit = (paddr[17:0] == PUA_ADDR_PULLUP) ||
                   (paddr[17:0] == PUA_ADDR_DIR) ||
                   (paddr[17:0] == PUA_ADDR_DATA);
        addr_hit = addr_hit && (paddr[31:18] == 14'h0000);
    end

    // Next register values; standby clears, software standby changes nothing.
    always_comb begin
        next_pin_direction     = pin_direction;
        next_pin_output_data   = pin_output_data;
        next_pin_pullup_enable = pin_pullup_enable;
        if (hw_standby) begin
            next_pin_direction     = PUA_RST_DIR;
            next_pin_output_data   = PUA_RST_DATA;
            next_pin_pullup_enable = PUA_RST_PULLUP;
        end else if (wr_en && pstrb[0] && addr_hit) begin
            // Software standby makes no change here.
            if (paddr[17:0] == PUA_ADDR_DIR &&
                mode != PUA_MODE_EXP_NOROM) begin
                next_pin_direction = pwdata[WIDTH-1:0];
            end
            if (paddr[17:0] == PUA_ADDR_DATA) begin
                next_pin_output_data = pwdata[WIDTH-1:0];
            end
            if (paddr[17:0] == PUA_ADDR_PULLUP) begin
                next_pin_pullup_enable = pwdata[WIDTH-1:0];
            end
        end
    end

    // Register the state; asynchronous reset loads constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction     <= PUA_RST_DIR;
            pin_output_data   <= PUA_RST_DATA;
            pin_pullup_enable <= PUA_RST_PULLUP;
            in_reset          <= 1'b1;
        end else begin
            pin_direction     <= next_pin_direction;
            pin_output_data   <= next_pin_output_data;
            pin_pullup_enable <= next_pin_pullup_enable;
            in_reset          <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin input synchroniser, two flops per pin.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One pin cell per port pin.

    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        pua_pin_cell u_cell (
            .mode       (mode),
            .hw_standby (hw_standby),
            .in_reset   (in_reset),
            .dir_bit    (pin_direction[i]),
            .data_bit   (pin_output_data[i]),
            .pullup_bit (pin_pullup_enable[i]),
            .addr_bit   (upper_addr[i]),
            .pin_sync   (pin_sync[i]),
            .pin_out    (pin_out[i]),
            .pin_oe     (pin_oe[i]),
            .pullup_on  (pullup_on[i]),
            .read_bit   (read_bits[i])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle, held in the access phase.

    always_comb begin
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (rd_en) begin
            next_prdata = 32'h0000_0000;
            if (!addr_hit) begin
                next_pslverr = 1'b0;
            end else if (paddr[17:0] == PUA_ADDR_DIR) begin
                next_prdata[WIDTH-1:0] = PUA_DIR_ONES;
            end else if (paddr[17:0] == PUA_ADDR_DATA) begin
                next_prdata[WIDTH-1:0] = read_bits;
            end else begin
                next_prdata[WIDTH-1:0] = pin_pullup_enable;
            end
        end
        if (psel && !penable) begin
            next_pslverr = !addr_hit;
        end else if (psel && penable) begin
            next_pslverr = pslverr;
        end
    end

    // Register read data and error flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule

/* rtl/pua_pkg.sv */
// Purpose: Shared constants for the upper address / general I/O port.
// Assumes: APB with 32-bit data; registers hold 8 bits in the low lane.
// Notes:   Printed offsets are not word aligned, so they are indices.
package pua_pkg;

    // Port width in pins.
    localparam int PUA_WIDTH = 8;

    // Register indices; the byte address is four times the index.
    localparam logic [15:0] PUA_IDX_PULLUP = 16'hFFAD;
    localparam logic [15:0] PUA_IDX_DIR    = 16'hFFB1;
    localparam logic [15:0] PUA_IDX_DATA   = 16'hFFB3;

    // Byte addresses derived from the indices.
    localparam logic [17:0] PUA_ADDR_PULLUP = {PUA_IDX_PULLUP, 2'b00};
    localparam logic [17:0] PUA_ADDR_DIR    = {PUA_IDX_DIR, 2'b00};
    localparam logic [17:0] PUA_ADDR_DATA   = {PUA_IDX_DATA, 2'b00};

    // Values after reset and hardware standby.
    localparam logic [7:0] PUA_RST_PULLUP = 8'h00;
    localparam logic [7:0] PUA_RST_DIR    = 8'h00;
    localparam logic [7:0] PUA_RST_DATA   = 8'h00;

    // Value the direction register shows in mode 1 and on every read.
    localparam logic [7:0] PUA_DIR_ONES = 8'hFF;

    // Operating mode codes on the mode input.
    localparam logic [1:0] PUA_MODE_EXP_NOROM = 2'h1;
    localparam logic [1:0] PUA_MODE_EXP_ROM   = 2'h2;
    localparam logic [1:0] PUA_MODE_SINGLE    = 2'h3;

endpackage

/* rtl/pua_pin_cell.sv */
// Purpose: One port pin: output select, enable, pull-up and readback.
// Assumes: Pin input already synchronised by the caller.
// Notes:   Purely combinational; one instance per pin.
`timescale 1ns/1ps
module pua_pin_cell
    import pua_pkg::*;
(
    // Mode and standby state.
    input  wire logic [1:0] mode,
    input  wire logic       hw_standby,
    input  wire logic       in_reset,
    // Register bits for this pin.
    input  wire logic       dir_bit,
    input  wire logic       data_bit,
    input  wire logic       pullup_bit,
    // Address bit and pin level.
    input  wire logic       addr_bit,
    input  wire logic       pin_sync,
    // Pin drive and readback.
    output logic            pin_out,
    output logic            pin_oe,
    output logic            pullup_on,
    output logic            read_bit
);

    // Mode 1 fixes direction at one; other modes use the stored bit.
    logic eff_dir;  // Effective direction of this pin.

    always_comb begin
        eff_dir = (mode == PUA_MODE_EXP_NOROM) ? 1'b1 : dir_bit;
    end

    // Drive selection per mode; hardware standby floats every pin.
    always_comb begin
        pin_out = 1'b0;
        pin_oe  = 1'b0;
        if (!hw_standby && !in_reset) begin
            unique case (mode)
                PUA_MODE_EXP_NOROM: begin
                    pin_out = addr_bit;
                    pin_oe  = 1'b1;
                end
                PUA_MODE_EXP_ROM: begin
                    pin_out = addr_bit;
                    pin_oe  = dir_bit;
                end
                PUA_MODE_SINGLE: begin
                    pin_out = data_bit;
                    pin_oe  = dir_bit;
                end
                default: begin
                    // Undefined mode code leaves the pin floating.
                    pin_out = 1'b0;
                    pin_oe  = 1'b0;
                end
            endcase
        end
        // Otherwise, as in reset, every pin floats with its driver off.
    end

    // Pull-up on only in modes 2 and 3, for an input with its bit set.
    always_comb begin
        pullup_on = 1'b0;
        if (!hw_standby && !in_reset &&
            (mode == PUA_MODE_EXP_ROM || mode == PUA_MODE_SINGLE)) begin
            pullup_on = pullup_bit && !dir_bit;
        end
    end

    // Output pins read back the data register; inputs read the pin.
    always_comb begin
        read_bit = eff_dir ? data_bit : pin_sync;
    end

endmodule

/* dv/pua_pin_model.sv */
// Purpose: Pin-side model: resolves each pin from port drive, bench drive
//          and pull-up.
// Assumes: Bench drive only on pins the port leaves as inputs.
// Notes:   A pin that nobody drives flips every cycle, so it is never
//          mistaken for a driven level.
`timescale 1ns/1ps
module pua_pin_model (
    // Clock.
    input  wire logic       pclk,
    // Port side.
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_on,
    // Outside drivers.
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_en,
    // Resolved level.
    output logic      [7:0] level
);
    logic [7:0] last = 8'h00;  // Level seen one cycle ago.

    // Record the previous level for floating pins.
    always_ff @(posedge pclk) begin
        last <= level;
    end

    // Resolve each pin: port first, then outside, then pull-up.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_drv[i] :
                       pullup_on[i] ? 1'b1 : ~last[i];
        end
    end
endmodule

/* dv/pua_port_checker.sv */
// Purpose: Concurrent checks on the port's pins and register reads.
// Assumes: One pclk domain; presetn active low.
// Notes:   The up flag skips the first edge after reset release.
`timescale 1ns/1ps
module pua_port_checker
    import pua_pkg::*;
#(
    parameter int WIDTH = PUA_WIDTH
)(
    // Clock and reset.
    input wire logic             pclk,
    input wire logic             presetn,
    // APB bus.
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [31:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [3:0]       pstrb,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // Mode and standby state.
    input wire logic [1:0]       mode,
    input wire logic             hw_standby,
    input wire logic             sw_standby,
    // Upper address and pins.
    input wire logic [WIDTH-1:0] upper_addr,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pullup_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic up;  // High from the second edge after release.

    // Track time since reset release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= 1'b0;
        end else begin
            up <= 1'b1;
        end
    end

    // A read: setup cycle to address a, then its access phase.
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence

    a_dir_read_ones: assert property (s_rd({14'h0, PUA_ADDR_DIR}) |->
        prdata == 32'h0000_00FF) else $error("direction read not ones");
    a_data_read_out: assert property (s_rd({14'h0, PUA_ADDR_DATA}) |->
        mode != PUA_MODE_SINGLE || ((prdata[7:0] ^ pin_out) & pin_oe) == '0)
        else $error("output pin read differs from drive");
    a_mode1_addr: assert property (up && !hw_standby && mode == 2'h1 |->
        pin_oe == '1 && pin_out == upper_addr) else $error("mode 1 pins");
    a_mode2_addr: assert property (up && !hw_standby && mode == 2'h2 |->
        ((pin_out ^ upper_addr) & pin_oe) == '0) else $error("mode 2 addr");
    a_hw_float: assert property (hw_standby && $past(hw_standby) |->
        pin_oe == '0 && pullup_on == '0) else $error("standby drive");
    a_mode1_nopull: assert property (mode == 2'h1 |-> pullup_on == '0)
        else $error("pull-up in mode 1");
    a_pull_input: assert property ((pullup_on & pin_oe) == '0)
        else $error("pull-up on output pin");
    a_sw_hold: assert property (up && $past(up) && sw_standby &&
        $stable(mode) && !hw_standby && !$past(hw_standby) &&
        !($past(psel) && $past(pwrite)) |->
        $stable(pin_oe) && $stable(pullup_on))
        else $error("pins moved in soft standby");
endmodule

bind pua_port pua_port_checker #(.WIDTH(WIDTH)) u_pua_port_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pstrb, .pready, .pslverr, .mode, .hw_standby, .sw_standby,
    .upper_addr, .pin_in, .pin_out, .pin_oe, .pullup_on);

/* dv/pua_port_tb.sv */
// Purpose: Directed bench for the upper address port.
// Assumes: Single-cycle APB access; pin input seen two edges late.
// Notes:   Scenarios run in order and reuse earlier register state.
`timescale 1ns/1ps
module pua_port_tb;
    import pua_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic hw_standby = 0, sw_standby = 0, pready, pslverr, er;
    logic [1:0] mode = PUA_MODE_SINGLE;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic [7:0] upper_addr = 8'h00, ext_drv = 8'h00, ext_en = 8'h00;
    logic [7:0] pin_in, pin_out, pin_oe, pullup_on;
    int err_total = 0, n_compared = 0, cyc = 0;
    localparam logic [31:0] A_PU = {14'h0, PUA_ADDR_PULLUP};
    localparam logic [31:0] A_DIR = {14'h0, PUA_ADDR_DIR};
    localparam logic [31:0] A_DAT = {14'h0, PUA_ADDR_DATA};

    always #20 pclk = ~pclk;

    pua_port u_pua_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .mode,
        .hw_standby, .sw_standby, .upper_addr, .pin_in, .pin_out, .pin_oe,
        .pullup_on);
    pua_pin_model u_pua_pin_model (.pclk, .pin_out, .pin_oe, .pullup_on,
        .ext_drv, .ext_en, .level(pin_in));

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Cut a hang short.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            close_out;
        end
    end

    task chk(input string n, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task pin8(input string n, input logic [7:0] e, g);
        chk(n, {24'h0, e}, {24'h0, g});
    endtask
    task fin(input string s);
        $display("test %s ended", s);
    endtask

    // One APB transfer, then one idle cycle; only the timeout ends a wait.
    task xfer(input logic w, input logic [31:0] a, d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task t_reset;
        ext_en <= 8'hFF;
        ext_drv <= 8'hC3;
        xfer(0, A_PU, 0);  chk("pullup", 32'h0, rd);
        pin8("oe", 8'h00, pin_oe);
        xfer(0, A_DAT, 0); chk("pins", 32'hC3, rd);
        xfer(0, A_DIR, 0); chk("dir", 32'hFF, rd);
        ext_en <= 8'h00;
        xfer(1, A_DIR, 32'hFF);
        xfer(0, A_DAT, 0); chk("data", 32'h0, rd);
        fin("reset");
    endtask
    task t_mode3;
        xfer(1, A_DIR, 32'hA5);
        ext_en <= 8'h42;
        ext_drv <= 8'h40;
        xfer(1, A_DAT, 32'h3C);
        xfer(1, A_PU, 32'hFF);
        pin8("oe", 8'hA5, pin_oe);
        pin8("out", 8'h24, pin_out & 8'hA5);
        pin8("pull", 8'h5A, pullup_on);
        // Pulled-up pins need two synchroniser edges before the read.
        @(posedge pclk);
        xfer(0, A_DAT, 0); chk("read", 32'h7C, rd);
        fin("mode3");
    endtask
    task t_sw;
        sw_standby <= 1'b1;
        repeat (3) @(posedge pclk);
        pin8("oe", 8'hA5, pin_oe);
        pin8("pull", 8'h5A, pullup_on);
        xfer(0, A_DAT, 0); chk("read", 32'h7C, rd);
        sw_standby <= 1'b0;
        fin("swstby");
    endtask
    task t_hw;
        ext_en <= 8'h00;
        hw_standby <= 1'b1;
        repeat (2) @(posedge pclk);
        pin8("oe", 8'h00, pin_oe);
        pin8("pull", 8'h00, pullup_on);
        hw_standby <= 1'b0;
        @(posedge pclk);
        pin8("oe", 8'h00, pin_oe);
        xfer(0, A_PU, 0); chk("pullup", 32'h0, rd);
        xfer(1, A_DIR, 32'hFF);
        xfer(0, A_DAT, 0); chk("data", 32'h0, rd);
        fin("hwstby");
    endtask
    task t_mode2;
        mode <= PUA_MODE_EXP_ROM;
        upper_addr <= 8'hA5;
        xfer(1, A_DIR, 32'hF0);
        pin8("oe", 8'hF0, pin_oe);
        pin8("addr", 8'hA0, pin_out & 8'hF0);
        fin("mode2");
    endtask
    task t_mode1;
        mode <= PUA_MODE_EXP_NOROM;
        upper_addr <= 8'h5A;
        xfer(1, A_DIR, 0);
        xfer(1, A_PU, 32'hFF);
        pin8("oe", 8'hFF, pin_oe);
        pin8("addr", 8'h5A, pin_out);
        pin8("pull", 8'h00, pullup_on);
        xfer(0, A_DIR, 0); chk("dir", 32'hFF, rd);
        // The mode 1 direction write must not have reached the register.
        mode <= PUA_MODE_EXP_ROM;
        @(posedge pclk);
        pin8("dir kept", 8'hF0, pin_oe);
        pin8("pull m2", 8'h0F, pullup_on);
        mode <= PUA_MODE_EXP_NOROM;
        hw_standby <= 1'b1;
        @(posedge pclk);
        pin8("float", 8'h00, pin_oe);
        hw_standby <= 1'b0;
        @(posedge pclk);
        pin8("oe m1", 8'hFF, pin_oe);
        fin("mode1");
    endtask
    task t_bad;
        xfer(1, 32'h10, 32'hFF); chk("err", 32'h1, {31'h0, er});
        xfer(0, 32'h10, 0); chk("bad read", 32'h0, rd);
        chk("err rd", 32'h1, {31'h0, er});
        fin("unmapped");
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_mode3;
        t_sw;
        t_hw;
        t_mode2;
        t_mode1;
        t_bad;
        close_out;
    end
endmodule
